/* hw/sarseq_pkg.sv */
`default_nettype none
package sarseq_pkg;
  // bus geometry
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] OFS_MODE = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_RESULT = 4'h4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // converter mode register fields
  localparam int BIT_ENABLE = 7;
  localparam int BIT_CHANNEL = 4;
  localparam int BIT_START = 3;
  localparam int BIT_EOC = 2;
  localparam logic [7:0] MODE_RESET = 8'h04;
  localparam logic [7:0] RESULT_RESET = 8'h7F;
  localparam logic [7:0] RESULT_DISABLED = 8'hFF;
  // timing, in main oscillator periods; the oscillator is aclk here
  localparam longint CLK_HZ = 40000000;
  localparam longint FX_HZ = 40000000;
  localparam int START_DELAY_PERIODS = 16;
  localparam int CONV_PERIODS = 168;
  localparam int RES_BITS = 8;
  localparam int START_DELAY_CYCLES = int'((START_DELAY_PERIODS * CLK_HZ) / FX_HZ);
  localparam int CONV_CYCLES = int'((CONV_PERIODS * CLK_HZ) / FX_HZ);
  localparam int STEP_CYCLES = CONV_CYCLES / RES_BITS;
  // sequencer states, gray along idle -> delay -> run
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_DELAY = 2'h1,
    ST_RUN = 2'h3
  } sarseq_state_e;
endpackage
`default_nettype wire

/* hw/sarseq_engine.sv */
`default_nettype none
module sarseq_engine #(
  parameter int BITS = 8,
  parameter int STEP = 21
) (
  input wire logic aclk, // system clock
  input wire logic aresetn, // sync reset, active low
  input wire logic start, // one-cycle launch
  input wire logic stall, // hold everything (stop mode)
  input wire logic comp, // comparator: input >= trial
  output logic busy, // conversion running
  output logic done, // one-cycle pulse, trial holds the result
  output logic [BITS-1:0] trial // current approximation to the dac
);
  localparam int CW = (STEP > 1) ? $clog2(STEP) : 1;
  localparam int IW = $clog2(BITS);
  localparam logic [CW-1:0] LAST = CW'(STEP - 1);

  logic [CW-1:0] cnt;
  logic [IW-1:0] idx;
  logic step_end;

  if (BITS < 2 || STEP < 1) begin : g_bad
    $error("sarseq_engine: unsupported BITS or STEP");
  end

  assign step_end = busy && !stall && (cnt == LAST);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      busy <= 1'b0;
      cnt <= '0;
      idx <= '0;
      trial <= '0;
    end
    else if (start)
    begin
      busy <= 1'b1;
      cnt <= '0;
      idx <= IW'(BITS - 1);
      trial <= BITS'(1) << (BITS - 1);
    end
    else if (busy && !stall)
    begin
      if (step_end)
      begin
        cnt <= '0;
        // msb first: drop the trial bit on a low decision, then try the next one
        if (idx == '0)
        begin
          trial <= comp ? trial : (trial & ~BITS'(1));
          busy <= 1'b0;
        end
        else
        begin
          trial <= (comp ? trial : (trial & ~(BITS'(1) << idx)))
                   | (BITS'(1) << (idx - IW'(1)));
          idx <= idx - IW'(1);
        end
      end
      else
      begin
        cnt <= cnt + CW'(1);
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      done <= 1'b0;
    else
      done <= step_end && (idx == '0);
  end
endmodule
`default_nettype wire

/* hw/sarseq_top.sv */
// How it works
// - channel select bit four picks input
// - enable and start both one begin conversion
// - start bit clears itself in hardware
// - hardware successive approximation fills result register
// - end flag bit two set when done
// - start and flag clear within sixteen periods
// - conversion lasts 168 oscillator periods
// - result is read only, writes ignored
// - result resets to 7F
// - new start discards previous result (the old result is kept until the new one overwrites it)
// - start while disabled stores FF
// - converter halts in stop standby mode
// - end flag zero while converting
// - mode register resets to 04
// - channel zero first input, one second
// - enable zero unused, one in use
//
// Chosen here: the address map and the AXI4-Lite register port.
`default_nettype none
module sarseq_top
  import sarseq_pkg::*;
(
  input wire logic aclk, // system clock, 40 MHz
  input wire logic aresetn, // sync reset, active low
  input wire logic [sarseq_pkg::ADDR_W-1:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [sarseq_pkg::ADDR_W-1:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic comp_in, // comparator decision pin
  input wire logic stop_mode, // chip stop standby request
  output logic chan_sel, // 0 first input, 1 second
  output logic ref_enable, // reference current path on
  output logic sample_hold, // sampling/holding the input
  output logic [7:0] dac_code // trial code to the comparator dac
);
  import sarseq_pkg::*;

  sarseq_state_e state;
  logic enable, channel, start, eoc;
  logic [7:0] result;
  logic [3:0] presc;
  logic comp_meta, comp_s, stop_meta, stop_s;
  logic launch, eng_busy, eng_done;
  logic [7:0] eng_trial;
  logic [ADDR_W-1:0] aw_addr;
  logic aw_full, w_full;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_fire, wr_mode, wr_result;
  logic [7:0] mode_rd;

  // pins come from outside the clock domain
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      comp_meta <= 1'b0;
      comp_s <= 1'b0;
      stop_meta <= 1'b0;
      stop_s <= 1'b0;
    end
    else
    begin
      comp_meta <= comp_in;
      comp_s <= comp_meta;
      stop_meta <= stop_mode;
      stop_s <= stop_meta;
    end
  end

  // AXI4-Lite write channel
  assign s_axi_awready = !aw_full && !s_axi_bvalid;
  assign s_axi_wready = !w_full && !s_axi_bvalid;
  assign wr_fire = aw_full && w_full && !s_axi_bvalid;
  assign wr_mode = wr_fire && (aw_addr == OFS_MODE) && w_strb[0];
  assign wr_result = wr_fire && (aw_addr == OFS_RESULT);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full <= 1'b0;
      aw_addr <= '0;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_full <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end
    else if (wr_fire)
      aw_full <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_full <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_full <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end
    else if (wr_fire)
      w_full <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end
    else if (wr_fire)
    begin
      s_axi_bvalid <= 1'b1;
      // the result register answers okay but keeps its value
      s_axi_bresp <= (aw_addr == OFS_MODE || wr_result) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // AXI4-Lite read channel
  assign s_axi_arready = !s_axi_rvalid;
  assign mode_rd = {enable, 2'b00, channel, start, eoc, 2'b00};

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      s_axi_rdata <= '0;
      if (s_axi_araddr == OFS_MODE)
        s_axi_rdata <= {24'h0, mode_rd};
      else if (s_axi_araddr == OFS_RESULT)
        s_axi_rdata <= {24'h0, result};
      else
        s_axi_rresp <= RESP_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // mode register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      enable <= MODE_RESET[BIT_ENABLE];
      channel <= MODE_RESET[BIT_CHANNEL];
    end
    else if (wr_mode)
    begin
      enable <= w_data[BIT_ENABLE];
      channel <= w_data[BIT_CHANNEL];
    end
  end

  // a write that sets start in the launch cycle wins and queues another run
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      start <= MODE_RESET[BIT_START];
    else if (wr_mode && w_data[BIT_START])
      start <= 1'b1;
    else if (launch)
      start <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      eoc <= MODE_RESET[BIT_EOC];
    else if (launch && enable)
      eoc <= 1'b0;
    else if (eng_done || launch)
      eoc <= 1'b1;
  end

  // start delay and sequencing
  // free prescaler of 2^4 periods: the launch waits for its wrap, 1 to 16 cycles
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      presc <= '0;
    else if (!stop_s)
      presc <= presc + 4'h1;
  end

  assign launch = (state == ST_DELAY) && (presc == 4'(START_DELAY_CYCLES - 1))
                  && !stop_s;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      state <= ST_IDLE;
    else
    begin
      case (state)
        // the delay opens on the write itself, so the launch lands 1 to 16 edges later
        ST_IDLE:
          if (start || (wr_mode && w_data[BIT_START]))
            state <= ST_DELAY;
        ST_DELAY:
          if (launch)
            state <= enable ? ST_RUN : ST_IDLE;
        ST_RUN:
          if (eng_done)
            state <= start ? ST_DELAY : ST_IDLE;
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  // the channel is frozen at launch so a mid-run write cannot move the mux
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      chan_sel <= 1'b0;
    else if (launch && enable)
      chan_sel <= channel;
  end

  sarseq_engine #(
    .BITS(RES_BITS),
    .STEP(STEP_CYCLES)
  ) u_engine (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(launch && enable),
    .stall(stop_s),
    .comp(comp_s),
    .busy(eng_busy),
    .done(eng_done),
    .trial(eng_trial)
  );

  // result keeps the old value until overwritten; its content is undefined then anyway
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      result <= RESULT_RESET;
    else if (launch && !enable)
      result <= RESULT_DISABLED;
    else if (eng_done)
      result <= eng_trial;
  end

  assign ref_enable = enable;
  assign sample_hold = eng_busy;
  assign dac_code = eng_trial;

  // checks
  // helper counters turn long spans into plain comparisons
  logic [4:0] wait_cnt;
  logic [8:0] run_cnt;
  always_ff @(posedge aclk)
  begin
    if (!aresetn || state != ST_DELAY)
      wait_cnt <= '0;
    else if (!stop_s)
      wait_cnt <= wait_cnt + 5'h01;
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn || launch)
      run_cnt <= '0;
    else if (eng_busy && !stop_s)
      run_cnt <= run_cnt + 9'h001;
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_launch_clears: assert property (launch && enable
    && !(wr_mode && w_data[BIT_START]) |=> !start && !eoc && eng_busy)
    else $error("launch did not clear start/eoc");
  a_delay_bound: assert property (wait_cnt <= 5'(START_DELAY_CYCLES))
    else $error("start delay too long");
  a_conv_length: assert property (eng_done |-> run_cnt == 9'(CONV_CYCLES))
    else $error("conversion length wrong");
  a_done_stores: assert property (eng_done |=> eoc && result == $past(eng_trial))
    else $error("result or eoc not set at done");
  a_disabled_ff: assert property (launch && !enable
    |=> result == RESULT_DISABLED && eoc) else $error("disabled start did not store FF");
  a_result_ro: assert property (wr_result && !eng_done && !launch |=> $stable(result))
    else $error("result register changed on write");
  a_reset_vals: assert property (!$past(aresetn) |-> mode_rd == MODE_RESET
    && result == RESULT_RESET) else $error("reset values wrong");
  a_stop_hold: assert property (stop_s && eng_busy
    |=> $stable(eng_trial) && eng_busy) else $error("converter moved in stop mode");
  a_eoc_busy: assert property (eng_busy |-> !eoc
    && (!$past(eng_busy) || $stable(chan_sel)))
    else $error("eoc or channel wrong while converting");
  a_no_start_off: assert property (state == ST_IDLE |=> !eng_busy || $past(eng_busy))
    else $error("conversion began without a launch");
  a_disabled_idle: assert property (launch && !enable
    |=> state == ST_IDLE && !eng_busy) else $error("disabled start ran the converter");
  a_msb_first: assert property (launch && enable |=> dac_code == 8'h80)
    else $error("first trial is not the msb");
  a_chan_latch: assert property (launch && enable |=> chan_sel == $past(channel))
    else $error("channel not latched at launch");
  a_ro_bresp: assert property (wr_result |=> s_axi_bvalid && s_axi_bresp == RESP_OKAY)
    else $error("result write not answered okay");

  c_conversion: cover property (launch && enable ##[1:200] eng_done);
  c_disabled: cover property (launch && !enable);
  c_stop_run: cover property (stop_s && eng_busy);
  c_requeue: cover property (eng_done && start);
  c_masked_write: cover property (wr_fire && aw_addr == OFS_MODE && !w_strb[0]);
endmodule
`default_nettype wire

/* tb/sarseq_analog_model.sv */
`default_nettype none
module sarseq_analog_model (
  input wire logic aclk, // system clock
  input wire logic chan_sel, // 0 first input, 1 second
  input wire logic sample_hold, // conversion window
  input wire logic [7:0] dac_code, // trial code
  input wire logic [7:0] level_first, // first analog input, as a code
  input wire logic [7:0] level_second, // second analog input, as a code
  output logic comp_in // input >= trial
);
  timeunit 1ns;
  timeprecision 1ps;
  logic idle_toggle = 1'h0;
  always_ff @(posedge aclk)
  begin
    idle_toggle <= !idle_toggle;
  end
  // outside a window the decision means nothing, so it keeps moving
  assign comp_in = sample_hold ?
    ((chan_sel ? level_second : level_first) >= dac_code) : idle_toggle;
endmodule
`default_nettype wire

/* tb/tb.sv */
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import sarseq_pkg::*;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [ADDR_W-1:0] awaddr = '0;
  logic [ADDR_W-1:0] araddr = '0;
  logic awvalid = 1'h0;
  logic wvalid = 1'h0;
  logic bready = 1'h0;
  logic arvalid = 1'h0;
  logic rready = 1'h0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = '0;
  logic stop_mode = 1'h0;
  logic [7:0] lvl_a = '0;
  logic [7:0] lvl_b = '0;
  logic awready, wready, bvalid, arready, rvalid, comp_in, chan_sel, ref_enable, sample_hold;
  logic [31:0] rdata;
  logic [1:0] bresp, rresp;
  logic [7:0] dac_code;
  int miscompares = 0;
  int checked = 0;
  int cyc = 0;

  sarseq_top u_dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .comp_in(comp_in), .stop_mode(stop_mode), .chan_sel(chan_sel),
    .ref_enable(ref_enable), .sample_hold(sample_hold), .dac_code(dac_code)
  );
  sarseq_analog_model u_analog (
    .aclk(aclk), .chan_sel(chan_sel), .sample_hold(sample_hold), .dac_code(dac_code),
    .level_first(lvl_a), .level_second(lvl_b), .comp_in(comp_in)
  );

  initial
  begin
    forever #12.5 aclk = !aclk;
  end
  always @(posedge aclk) cyc <= cyc + 1;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // payload is held until each channel's own ready, then dropped
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s,
    output logic [1:0] resp);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do
    begin
      @(posedge aclk);
      if (awready)
        awvalid <= 1'h0;
      if (wready)
        wvalid <= 1'h0;
    end
    while (awvalid || wvalid);
    do @(posedge aclk); while (!bvalid);
    resp = bresp;
    bready <= 1'h0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] resp);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'h0;
    do @(posedge aclk); while (!rvalid);
    d = rdata;
    resp = rresp;
    rready <= 1'h0;
  endtask

  function automatic logic [7:0] sar_expect(input logic [7:0] lv);
    logic [7:0] code;
    code = 8'h0;
    for (int b = 7; b >= 0; b--)
    begin
      code[b] = 1'h1;
      if (lv < code)
        code[b] = 1'h0;
    end
    return code;
  endfunction

  task automatic convert(input logic ch, input logic [7:0] lv, input logic halt);
    logic [31:0] d;
    logic [1:0] r;
    int t0;
    wr(OFS_MODE, {24'h0, 1'h1, 2'h0, ch, 4'h8}, 4'hF, r);
    t0 = cyc;
    // launch lands within sixteen edges of the write
    repeat (30) @(posedge aclk);
    check(chan_sel, ch, "channel pin");
    check(sample_hold, 1'h1, "sampling");
    rd(OFS_MODE, d, r);
    check(d, {24'h0, 1'h1, 2'h0, ch, 4'h0}, "mode mid run");
    if (halt)
    begin
      stop_mode <= 1'h1;
      repeat (40) @(posedge aclk);
      stop_mode <= 1'h0;
    end
    do rd(OFS_MODE, d, r); while (!d[BIT_EOC]);
    check((cyc - t0 >= (halt ? 210 : 170)) && (cyc - t0 <= (halt ? 232 : 192)), 1'h1,
      "duration");
    check(d, {24'h0, 1'h1, 2'h0, ch, 4'h4}, "mode done");
    rd(OFS_RESULT, d, r);
    check(d, {24'h0, sar_expect(lv)}, "result");
    check(dac_code, sar_expect(lv), "final trial");
  endtask

  initial
  begin
    logic [31:0] d;
    logic [1:0] r;
    logic [7:0] lv;
    logic [7:0] corner [4];
    corner = '{8'h00, 8'hFF, 8'h80, 8'h7F};
    void'($urandom(14));
    repeat (6) @(posedge aclk);
    aresetn <= 1'h1;
    rd(OFS_MODE, d, r);
    check(d, 32'(MODE_RESET), "mode reset");
    rd(OFS_RESULT, d, r);
    check(d, 32'(RESULT_RESET), "result reset");
    check(ref_enable, 1'h0, "reference off");
    wr(OFS_RESULT, 32'h55, 4'hF, r);
    check(r, RESP_OKAY, "result write response");
    rd(OFS_RESULT, d, r);
    check(d, 32'(RESULT_RESET), "result written");
    wr(4'hC, 32'h0, 4'hF, r);
    check(r, RESP_SLVERR, "unmapped write");
    rd(4'h8, d, r);
    check(r, RESP_SLVERR, "unmapped read");
    // low byte strobe off: the start must not be seen
    wr(OFS_MODE, 32'h88, 4'hE, r);
    repeat (20) @(posedge aclk);
    rd(OFS_MODE, d, r);
    check(d, 32'(MODE_RESET), "masked start");
    wr(OFS_MODE, 32'h08, 4'hF, r);
    repeat (20) @(posedge aclk);
    rd(OFS_MODE, d, r);
    check(d, 32'(MODE_RESET), "disabled start");
    rd(OFS_RESULT, d, r);
    check(d, 32'(RESULT_DISABLED), "disabled result");
    for (int i = 0; i < 8; i++)
    begin
      lv = (i < 4) ? corner[i] : 8'($urandom);
      lvl_a <= i[0] ? 8'($urandom) : lv;
      lvl_b <= i[0] ? lv : 8'($urandom);
      convert(i[0], lv, i == 5);
      check(ref_enable, 1'h1, "reference on");
    end
    // reference current cut before standby
    wr(OFS_MODE, 32'h0, 4'hF, r);
    check(ref_enable, 1'h0, "reference cut");
    test_done();
  end

  initial
  begin
    repeat (20000) @(posedge aclk);
    miscompares++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    test_done();
  end
endmodule
`default_nettype wire
